// ---- rtl/per_pkg.sv ----
// Package of constants, codes and types for the programmer error reporter
//
// How it works
// [R1] A failed command makes the block send ERROR: and the code as two hex digits to the host.
// [R2] Target statuses command-number, parameter and checksum error report 04, 05 and 07.
// [R3] Target statuses verification, protection and negative acknowledge report 0F, 10 and 15.
// [R4] Target statuses erasure, blank and write error report 1A, 1B and 1C.
// [R5] Target statuses frequency and ID authentication error report 23 and 24.
// [R6] An unknown host command or bad parameter data reports F9.
// [R7] Host data overflowing the receive buffer reports FA.
// [R8] The host uses XON/XOFF flow control so that the receive buffer is not overrun.
// [R9] A malformed S-record received during load-image or erase-program reports FB.
// [R10] S-records whose addresses do not ascend also report FB.
// [R11] A target exchange that runs past its allowed time reports FC.
// [R12] A load-image S-record address outside the permitted flash ranges reports FD.
// [R13] A target packet with a bad format reports FE.
// [R14] Any internal failure or unexpected state reports FF.
// [R15] Load-image may use code flash 0x00000-0x7FFFF and data flash 0xF1000-0xF2FFF only.
// [R16] Erase-program sends PASS after each phase that completes: connect, erase and write.
// [R17] After an error text the command is dropped and the block waits for the next command.
package per_pkg;

    localparam int CLK_MHZ         = 50;
    localparam int TGT_TIMEOUT_US  = 1000;
    localparam int TGT_TIMEOUT_CYC = TGT_TIMEOUT_US * CLK_MHZ;

    // Error codes; target status bytes carry the same values
    localparam logic [7:0] ERR_CMD_NUM = 8'h04;
    localparam logic [7:0] ERR_PARAM   = 8'h05;
    localparam logic [7:0] ERR_CSUM    = 8'h07;
    localparam logic [7:0] ERR_VERIFY  = 8'h0F;
    localparam logic [7:0] ERR_PROT    = 8'h10;
    localparam logic [7:0] ERR_NEG_ACK = 8'h15;
    localparam logic [7:0] ERR_ERASE   = 8'h1A;
    localparam logic [7:0] ERR_BLANK   = 8'h1B;
    localparam logic [7:0] ERR_WRITE   = 8'h1C;
    localparam logic [7:0] ERR_FREQ    = 8'h23;
    localparam logic [7:0] ERR_ID_AUTH = 8'h24;
    localparam logic [7:0] ERR_HOST    = 8'hF9;
    localparam logic [7:0] ERR_OVR     = 8'hFA;
    localparam logic [7:0] ERR_SREC    = 8'hFB;
    localparam logic [7:0] ERR_TMO     = 8'hFC;
    localparam logic [7:0] ERR_RANGE   = 8'hFD;
    localparam logic [7:0] ERR_PKT     = 8'hFE;
    localparam logic [7:0] ERR_SYS     = 8'hFF;

    // Failure sources, lowest index has highest priority
    localparam int NUM_FLAGS = 8;
    localparam int F_SYS = 0;
    localparam int F_TMO = 1;
    localparam int F_PKT = 2;
    localparam int F_ST  = 3;
    localparam int F_FMT = 4;
    localparam int F_RNG = 5;
    localparam int F_CMD = 6;
    localparam int F_OVR = 7;
    localparam logic [7:0] ERR_BY_PRIO [0:NUM_FLAGS-1] =
        '{ERR_SYS, ERR_TMO, ERR_PKT, ERR_PKT, ERR_SREC, ERR_RANGE, ERR_HOST, ERR_OVR};

    localparam logic [31:0] CF_LO = 32'h0000_0000;
    localparam logic [31:0] CF_HI = 32'h0007_FFFF;
    localparam logic [31:0] DF_LO = 32'h000F_1000;
    localparam logic [31:0] DF_HI = 32'h000F_2FFF;

    // Text bytes
    localparam logic [7:0] ERR_TXT [0:5] = '{8'h45, 8'h52, 8'h52, 8'h4F, 8'h52, 8'h3A};
    localparam logic [7:0] PASS_TXT [0:3] = '{8'h50, 8'h41, 8'h53, 8'h53};
    localparam logic [7:0] CH_CR      = 8'h0D;
    localparam logic [7:0] CH_LF      = 8'h0A;
    localparam logic [7:0] CH_DIGIT   = 8'h30;
    localparam logic [7:0] CH_LETTER  = 8'h37;
    localparam logic [3:0] ERR_LEN    = 4'hA;
    localparam logic [3:0] PASS_LEN   = 4'h6;
    localparam logic [3:0] ERR_PFX    = 4'h6;
    localparam logic [3:0] PASS_PFX   = 4'h4;
    localparam logic [3:0] NIB_TEN    = 4'hA;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_ERR  = 2'b10
    } per_state_e;

endpackage

// ---- rtl/per_text_tx.sv ----
// Byte sender for the ERROR:XX and PASS host texts
`timescale 1ns/100ps
module per_text_tx (
    input  wire logic       core_clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       start_i,
    input  wire logic       pass_i,
    input  wire logic [7:0] code_i,
    input  wire logic       tx_ready_i,
    output logic      [7:0] tx_data_o,
    output logic            tx_valid_o,
    output logic            busy_o
);

    logic       pass_txt;
    logic [7:0] code;
    logic [3:0] idx;
    logic       next_busy;
    logic       next_pass_txt;
    logic [7:0] next_code;
    logic [3:0] next_idx;
    logic [7:0] next_data;
    logic       next_valid;

    function automatic logic [7:0] hex_char(input logic [3:0] nib);
        hex_char = (nib < per_pkg::NIB_TEN) ? per_pkg::CH_DIGIT + {4'h0, nib}
                                            : per_pkg::CH_LETTER + {4'h0, nib};
    endfunction

    function automatic logic [7:0] msg_char(input logic p, input logic [7:0] c,
                                            input logic [3:0] i);
        logic [3:0] pfx;
        pfx = p ? per_pkg::PASS_PFX : per_pkg::ERR_PFX;
        if (i < pfx) begin
            msg_char = p ? per_pkg::PASS_TXT[i[1:0]] : per_pkg::ERR_TXT[i[2:0]];
        end else if (!p && i == pfx) begin
            msg_char = hex_char(c[7:4]);
        end else if (!p && i == pfx + 4'h1) begin
            msg_char = hex_char(c[3:0]);
        end else if (i == (p ? per_pkg::PASS_LEN : per_pkg::ERR_LEN) - 4'h2) begin
            msg_char = per_pkg::CH_CR;
        end else begin
            msg_char = per_pkg::CH_LF;
        end
    endfunction

    always_comb begin
        next_busy     = busy_o;
        next_pass_txt = pass_txt;
        next_code     = code;
        next_idx      = idx;
        next_data     = tx_data_o;
        next_valid    = tx_valid_o;
        if (!busy_o && start_i) begin
            next_busy     = 1'b1;
            next_pass_txt = pass_i;
            next_code     = code_i;
            next_idx      = 4'h0;
            next_data     = msg_char(pass_i, code_i, 4'h0);
            next_valid    = 1'b1;
        end else if (tx_valid_o && tx_ready_i) begin
            if (idx == (pass_txt ? per_pkg::PASS_LEN : per_pkg::ERR_LEN) - 4'h1) begin
                next_busy  = 1'b0;
                next_valid = 1'b0;
            end else begin
                next_idx  = idx + 4'h1;
                next_data = msg_char(pass_txt, code, idx + 4'h1);
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            busy_o     <= 1'b0;
            pass_txt   <= 1'b0;
            code       <= 8'h00;
            idx        <= 4'h0;
            tx_data_o  <= 8'h00;
            tx_valid_o <= 1'b0;
        end else begin
            busy_o     <= next_busy;
            pass_txt   <= next_pass_txt;
            code       <= next_code;
            idx        <= next_idx;
            tx_data_o  <= next_data;
            tx_valid_o <= next_valid;
        end
    end

endmodule // per_text_tx

// ---- rtl/per_error_reporter.sv ----
// Error classification and reporting for the flash programmer command flow
`timescale 1ns/100ps
module per_error_reporter #(
    parameter int         TIMEOUT_CYC = per_pkg::TGT_TIMEOUT_CYC,
    parameter logic [7:0] ST_ACK      = 8'h06
) (
    input  wire logic        core_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        cmd_start_i,
    input  wire logic        cmd_is_ep_i,
    input  wire logic        cmd_done_i,
    input  wire logic        host_cmd_bad_i,
    input  wire logic        host_overrun_i,
    input  wire logic        rec_valid_i,
    input  wire logic [31:0] rec_addr_i,
    input  wire logic        rec_bad_i,
    input  wire logic        tgt_wait_i,
    input  wire logic        tgt_status_valid_i,
    input  wire logic [7:0]  tgt_status_i,
    input  wire logic        tgt_pkt_bad_i,
    input  wire logic        phase_pass_i,
    input  wire logic        sys_fault_i,
    input  wire logic        tx_ready_i,
    output logic      [7:0]  tx_data_o,
    output logic             tx_valid_o,
    output logic             abort_o,
    output logic             busy_o,
    output logic      [7:0]  err_code_o
);

    localparam int TW = $clog2(TIMEOUT_CYC + 1);
    localparam logic [TW-1:0] TMO_LAST = TW'(TIMEOUT_CYC - 1);
    // One queued PASS per phase; phases can finish faster than the host drains text
    localparam logic [1:0]    PASS_MAX = 2'h3;

    per_pkg::per_state_e state;
    per_pkg::per_state_e next_state;
    logic                          err_pend;
    logic                          next_err_pend;
    logic [7:0]                    err_code;
    logic [7:0]                    next_err_code;
    logic [1:0]                    pass_pend;
    logic [1:0]                    next_pass_pend;
    logic                          is_ep;
    logic                          next_is_ep;
    logic                          rec_seen;
    logic                          next_rec_seen;
    logic [31:0]                   last_addr;
    logic [31:0]                   next_last_addr;
    logic [TW-1:0]                 tmo_cnt;
    logic [TW-1:0]                 next_tmo_cnt;
    logic                          next_abort;
    logic                          next_busy;
    logic [7:0]                    next_err_out;
    logic [per_pkg::NUM_FLAGS-1:0] flags;
    logic                          hit;
    logic                          run;
    logic                          txt_start;
    logic                          txt_pass;
    logic                          tx_busy;

    function automatic logic known_status(input logic [7:0] s);
        case (s)
            per_pkg::ERR_CMD_NUM, per_pkg::ERR_PARAM, per_pkg::ERR_CSUM,
            per_pkg::ERR_VERIFY, per_pkg::ERR_PROT, per_pkg::ERR_NEG_ACK,
            per_pkg::ERR_ERASE, per_pkg::ERR_BLANK, per_pkg::ERR_WRITE,
            per_pkg::ERR_FREQ, per_pkg::ERR_ID_AUTH: known_status = 1'b1;
            default:                                  known_status = 1'b0;
        endcase
    endfunction

    function automatic logic in_range(input logic [31:0] a);
        in_range = (a >= per_pkg::CF_LO && a <= per_pkg::CF_HI) ||
                   (a >= per_pkg::DF_LO && a <= per_pkg::DF_HI);
    endfunction

    // Highest-priority source wins when several fail together
    function automatic logic [7:0] pick_code(input logic [per_pkg::NUM_FLAGS-1:0] f,
                                             input logic [7:0] s);
        pick_code = per_pkg::ERR_SYS;
        for (int i = per_pkg::NUM_FLAGS - 1; i >= 0; i--) begin
            if (f[i]) begin
                if (i == per_pkg::F_ST && known_status(s)) begin
                    pick_code = s;
                end else begin
                    pick_code = per_pkg::ERR_BY_PRIO[i];
                end
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Failure detection

    assign run = (state == per_pkg::ST_RUN);

    always_comb begin
        flags               = '0;
        flags[per_pkg::F_SYS] = sys_fault_i                                          // [R14]
                              | (cmd_start_i && state != per_pkg::ST_IDLE)
                              | (phase_pass_i && !(run && is_ep));
        flags[per_pkg::F_TMO] = run && tgt_wait_i && tmo_cnt == TMO_LAST;            // [R11]
        flags[per_pkg::F_PKT] = run && tgt_pkt_bad_i;                                // [R13]
        // Unknown status bytes are treated as a malformed packet
        flags[per_pkg::F_ST]  = run && tgt_status_valid_i && tgt_status_i != ST_ACK; // [R2]
        flags[per_pkg::F_FMT] = run && (rec_bad_i                                    // [R9]
                              || (rec_valid_i && rec_seen && rec_addr_i <= last_addr)); // [R10]
        flags[per_pkg::F_RNG] = run && !is_ep && rec_valid_i                         // [R12]
                              && !in_range(rec_addr_i);                              // [R15]
        flags[per_pkg::F_CMD] = host_cmd_bad_i;                                      // [R6]
        flags[per_pkg::F_OVR] = host_overrun_i;                                      // [R7]
        hit                   = |flags;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command sequencing

    always_comb begin
        next_state     = state;
        next_err_pend  = err_pend;
        next_err_code  = err_code;
        next_pass_pend = pass_pend;
        next_is_ep     = is_ep;
        next_rec_seen  = rec_seen;
        next_last_addr = last_addr;
        next_abort     = 1'b0;
        next_err_out   = err_code_o;
        txt_start      = 1'b0;
        txt_pass       = 1'b0;
        next_tmo_cnt   = (run && tgt_wait_i && !flags[per_pkg::F_TMO]) ? tmo_cnt + 1'b1 : '0;
        // Failures while the error text goes out are consequences and are dropped
        if (state != per_pkg::ST_ERR && !err_pend && hit) begin
            next_err_pend = 1'b1;
            next_err_code = pick_code(flags, tgt_status_i);                          // [R3] [R4] [R5]
        end
        if (run && phase_pass_i && is_ep && pass_pend != PASS_MAX) begin
            next_pass_pend = pass_pend + 2'h1;
        end
        if (run && rec_valid_i) begin
            next_rec_seen  = 1'b1;
            next_last_addr = rec_addr_i;
        end
        if (state != per_pkg::ST_ERR && err_pend && !tx_busy) begin
            txt_start    = 1'b1;                                                     // [R1]
            next_err_out = err_code;
            next_state   = per_pkg::ST_ERR;
        end else begin
            if (state != per_pkg::ST_ERR && pass_pend != 2'h0 && !tx_busy) begin
                txt_start      = 1'b1;                                               // [R16]
                txt_pass       = 1'b1;
                next_pass_pend = next_pass_pend - 2'h1;
            end
            if (state == per_pkg::ST_IDLE && cmd_start_i && !hit) begin
                next_state    = per_pkg::ST_RUN;
                next_is_ep    = cmd_is_ep_i;
                next_rec_seen = 1'b0;
            end
            if (run && cmd_done_i && !hit) begin
                next_state = per_pkg::ST_IDLE;
            end
            if (state == per_pkg::ST_ERR && !tx_busy) begin
                next_state     = per_pkg::ST_IDLE;                                   // [R17]
                next_err_pend  = 1'b0;
                next_pass_pend = 2'h0;
                next_abort     = 1'b1;
            end
        end
        next_busy = (next_state != per_pkg::ST_IDLE);
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state      <= per_pkg::ST_IDLE;
            err_pend   <= 1'b0;
            err_code   <= 8'h00;
            pass_pend  <= 2'h0;
            is_ep      <= 1'b0;
            rec_seen   <= 1'b0;
            last_addr  <= 32'h0000_0000;
            tmo_cnt    <= '0;
            abort_o    <= 1'b0;
            busy_o     <= 1'b0;
            err_code_o <= 8'h00;
        end else begin
            state      <= next_state;
            err_pend   <= next_err_pend;
            err_code   <= next_err_code;
            pass_pend  <= next_pass_pend;
            is_ep      <= next_is_ep;
            rec_seen   <= next_rec_seen;
            last_addr  <= next_last_addr;
            tmo_cnt    <= next_tmo_cnt;
            abort_o    <= next_abort;
            busy_o     <= next_busy;
            err_code_o <= next_err_out;
        end
    end

    per_text_tx u_text (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .start_i    (txt_start),
        .pass_i     (txt_pass),
        .code_i     (err_code),
        .tx_ready_i (tx_ready_i),
        .tx_data_o  (tx_data_o),
        .tx_valid_o (tx_valid_o),
        .busy_o     (tx_busy)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_err_launch;
        state != per_pkg::ST_ERR && err_pend && !tx_busy;
    endsequence

    sequence s_err_finish;
        state == per_pkg::ST_ERR && !tx_busy;
    endsequence

    a_err_text_start: assert property (s_err_launch |=> state == per_pkg::ST_ERR && tx_busy // [R1]
        && tx_data_o == per_pkg::ERR_TXT[0] && err_code_o == $past(err_code))
        else $error("error text did not start");
    a_status_map: assert property ((run && !err_pend && flags == 8'h08                       // [R2] [R3] [R4] [R5]
        && known_status(tgt_status_i)) |=> err_pend && err_code == $past(tgt_status_i))
        else $error("target status mapped wrongly");
    a_host_bad: assert property ((state != per_pkg::ST_ERR && !err_pend && flags == 8'h40)  // [R6]
        |=> err_code == per_pkg::ERR_HOST) else $error("host command error code wrong");
    a_host_ovr: assert property ((state != per_pkg::ST_ERR && !err_pend && flags == 8'h80)  // [R7]
        |=> err_code == per_pkg::ERR_OVR) else $error("overrun code wrong");
    a_srec_order: assert property ((run && !err_pend && rec_valid_i && rec_seen             // [R10]
        && rec_addr_i <= last_addr && flags[3:0] == 4'h0) |=> err_code == per_pkg::ERR_SREC)
        else $error("descending record not flagged");
    a_srec_range: assert property ((run && !err_pend && !is_ep && rec_valid_i               // [R12]
        && !in_range(rec_addr_i) && flags[4:0] == 5'h00) |=> err_code == per_pkg::ERR_RANGE)
        else $error("out of range record not flagged");
    a_tgt_timeout: assert property ((run && !err_pend && tgt_wait_i && tmo_cnt == TMO_LAST // [R11]
        && !flags[per_pkg::F_SYS]) |=> err_pend && err_code == per_pkg::ERR_TMO)
        else $error("target timeout not flagged");
    a_sys_fault: assert property ((state != per_pkg::ST_ERR && !err_pend && sys_fault_i)    // [R14]
        |=> err_code == per_pkg::ERR_SYS) else $error("system fault code wrong");
    a_pass_text: assert property ((state != per_pkg::ST_ERR && !err_pend && pass_pend != 2'h0 // [R16]
        && !tx_busy) |=> tx_busy && tx_data_o == per_pkg::PASS_TXT[0])
        else $error("pass text did not start");
    a_abort_idle: assert property (s_err_finish |=> abort_o && state == per_pkg::ST_IDLE    // [R17]
        && !err_pend ##1 !abort_o) else $error("failed command not abandoned");

endmodule // per_error_reporter

// ---- testbench/per_host_model.sv ----
// Host side model that takes the text bytes and paces them
`timescale 1ns/100ps
module per_host_model (
    input  wire logic       core_clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       slow_i,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_valid_i,
    output logic            tx_ready_o
);
    logic [7:0] rx_q [$];
    logic [1:0] pace;

    ////////////////////////////////////////////////////////////////////////////////
    // Slow host holds off two cycles of three, as a throttling host would
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pace <= 2'h0;
        end else begin
            if (tx_valid_i && tx_ready_o) begin
                rx_q.push_back(tx_data_i);
            end
            pace <= (pace == 2'h2) ? 2'h0 : pace + 2'h1;
        end
    end
    assign tx_ready_o = slow_i ? (pace == 2'h2) : 1'b1;
endmodule // per_host_model

// ---- testbench/per_error_reporter_tb.sv ----
// Self-checking bench for the error reporter
`timescale 1ns/100ps
module per_error_reporter_tb;
    typedef struct {logic [3:0] kind; logic [7:0] val; logic [7:0] exp;} per_row_s;
    logic        clk = 1'b0, reset_n = 1'b0, slow = 1'b0;
    logic        cmd_start = 1'b0, cmd_is_ep = 1'b0, cmd_done = 1'b0, host_cmd_bad = 1'b0;
    logic        host_overrun = 1'b0, rec_valid = 1'b0, rec_bad = 1'b0, tgt_wait = 1'b0;
    logic        tgt_status_valid = 1'b0, tgt_pkt_bad = 1'b0, phase_pass = 1'b0;
    logic        sys_fault = 1'b0, tx_ready, tx_valid, abort, busy;
    logic [31:0] rec_addr = 32'h0;
    logic [7:0]  tgt_status = 8'h00, tx_data, err_code;
    int          bad_count = 0, comparisons = 0;
    logic [31:0] addrs [0:4] = '{32'h0, 32'h7FFFF, 32'hF1000, 32'hF2FFF, 32'hF3000};
    logic [7:0]  pass_b [0:5] = '{8'h50, 8'h41, 8'h53, 8'h53, 8'h0D, 8'h0A};
    // Kinds: 0 status, 1 bad cmd, 2 overrun, 3 bad record, 4 bad packet, 5 fault,
    // 7 target wait held, 8 second start
    per_row_s rows [0:18] = '{'{0, 8'h04, 8'h04}, '{0, 8'h05, 8'h05}, '{0, 8'h07, 8'h07},
        '{0, 8'h0F, 8'h0F}, '{0, 8'h10, 8'h10}, '{0, 8'h15, 8'h15}, '{0, 8'h1A, 8'h1A},
        '{0, 8'h1B, 8'h1B}, '{0, 8'h1C, 8'h1C}, '{0, 8'h23, 8'h23}, '{0, 8'h24, 8'h24},
        '{0, 8'h99, 8'hFE}, '{1, 8'h00, 8'hF9}, '{2, 8'h00, 8'hFA}, '{3, 8'h00, 8'hFB},
        '{4, 8'h00, 8'hFE}, '{5, 8'h00, 8'hFF}, '{7, 8'h00, 8'hFC}, '{8, 8'h00, 8'hFF}};

    always #10 clk = ~clk;

    per_error_reporter #(.TIMEOUT_CYC(20)) per_error_reporter_inst (
        .core_clk_i(clk), .reset_n_i(reset_n), .cmd_start_i(cmd_start),
        .cmd_is_ep_i(cmd_is_ep), .cmd_done_i(cmd_done), .host_cmd_bad_i(host_cmd_bad),
        .host_overrun_i(host_overrun), .rec_valid_i(rec_valid), .rec_addr_i(rec_addr),
        .rec_bad_i(rec_bad), .tgt_wait_i(tgt_wait), .tgt_status_valid_i(tgt_status_valid),
        .tgt_status_i(tgt_status), .tgt_pkt_bad_i(tgt_pkt_bad), .phase_pass_i(phase_pass),
        .sys_fault_i(sys_fault), .tx_ready_i(tx_ready), .tx_data_o(tx_data),
        .tx_valid_o(tx_valid), .abort_o(abort), .busy_o(busy), .err_code_o(err_code));

    per_host_model per_host_model_inst (.core_clk_i(clk), .reset_n_i(reset_n),
        .slow_i(slow), .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    function automatic logic [7:0] hexch(input logic [3:0] n);
        return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
    endfunction

    task automatic close_out();
        $display("bad_count %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic run_cmd(input logic ep);
        cmd_is_ep = ep;
        cmd_start = 1'b1;
        tick();
        cmd_start = 1'b0;
        tick();
    endtask

    task automatic record(input logic [31:0] a);
        rec_addr = a;
        rec_valid = 1'b1;
        tick();
        rec_valid = 1'b0;
        tick();
    endtask

    // Waits for the abort pulse, then checks it and the error text
    task automatic expect_error(input logic [7:0] code);
        logic [7:0] exp_b [0:9];
        exp_b = '{8'h45, 8'h52, 8'h52, 8'h4F, 8'h52, 8'h3A, hexch(code[7:4]),
                  hexch(code[3:0]), 8'h0D, 8'h0A};
        for (int i = 0; i < 400 && abort !== 1'b1; i++) tick();
        tgt_wait = 1'b0;
        check8({7'h0, abort}, 8'h01, "abort");
        check8({7'h0, busy}, 8'h00, "busy");
        check8(err_code, code, "code");
        check8(8'(per_host_model_inst.rx_q.size()), 8'h0A, "text length");
        for (int i = 0; i < 10 && per_host_model_inst.rx_q.size() > 0; i++)
            check8(per_host_model_inst.rx_q.pop_front(), exp_b[i], "text byte");
        per_host_model_inst.rx_q.delete();
        tick();
        check8({7'h0, abort}, 8'h00, "abort pulse");
    endtask

    task automatic do_row(input per_row_s r);
        run_cmd(1'b0);
        case (r.kind)
            0: begin tgt_status_valid = 1'b1; tgt_status = r.val; end
            1: host_cmd_bad = 1'b1;
            2: host_overrun = 1'b1;
            3: rec_bad = 1'b1;
            4: tgt_pkt_bad = 1'b1;
            5: sys_fault = 1'b1;
            7: tgt_wait = 1'b1;
            default: cmd_start = 1'b1;
        endcase
        tick();
        {tgt_status_valid, host_cmd_bad, host_overrun, rec_bad} = 4'h0;
        {tgt_pkt_bad, sys_fault, cmd_start} = 3'h0;
        expect_error(r.exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(20 * 20000);
        bad_count++;
        close_out();
    end

    initial begin
        repeat (10) tick();
        check8({tx_valid, abort, busy, 5'h0} | err_code, 8'h00, "reset outputs");
        reset_n = 1'b1;
        tick();
        check8({tx_valid, abort, busy, 5'h0} | err_code, 8'h00, "after release");
        // Boundary addresses pass, the first one past data flash fails
        run_cmd(1'b0);
        for (int i = 0; i < 4; i++) record(addrs[i]);
        check8({6'h0, busy, tx_valid}, 8'h02, "in range");
        record(addrs[4]);
        expect_error(8'hFD);
        run_cmd(1'b0);
        record(32'h200);
        record(32'h200);
        expect_error(8'hFB);
        for (int i = 0; i < 19; i++) begin
            slow = i[0];
            do_row(rows[i]);
        end
        // Erase-program with a slow host and a target wait of 15 cycles, five short of timing out
        slow = 1'b1;
        run_cmd(1'b1);
        record(addrs[4]);
        tgt_wait = 1'b1;
        repeat (15) tick();
        tgt_wait = 1'b0;
        repeat (3) begin
            phase_pass = 1'b1;
            tick();
            phase_pass = 1'b0;
            tick();
        end
        cmd_done = 1'b1;
        tick();
        cmd_done = 1'b0;
        for (int i = 0; i < 400 && per_host_model_inst.rx_q.size() < 18; i++) tick();
        repeat (3) tick();
        check8(8'(per_host_model_inst.rx_q.size()), 8'h12, "pass texts");
        for (int i = 0; i < 18 && per_host_model_inst.rx_q.size() > 0; i++)
            check8(per_host_model_inst.rx_q.pop_front(), pass_b[i % 6], "pass byte");
        check8({6'h0, busy, tx_valid}, 8'h00, "ep end");
        close_out();
    end
endmodule // per_error_reporter_tb
